// ==== src/vsx_map.svh ====
`ifndef VSX_MAP_SVH
`define VSX_MAP_SVH
// ----------------------------------------
// Register word offsets (compared against haddr[13:2])
// ----------------------------------------
`define VSX_OFS_PRI1 12'h006
`define VSX_OFS_TRAP 12'h080
`define VSX_OFS_VEC 12'h082
`define VSX_OFS_FLAG0 12'h084
`define VSX_OFS_FLAG1 12'h086
`define VSX_OFS_FLAG2 12'h088
`define VSX_OFS_EN0 12'h08c
`define VSX_OFS_EN1 12'h08e
`define VSX_OFS_PRI0 12'h094
`define VSX_OFS_PRI2 12'h098
`define VSX_OFS_PRI3 12'h09a
`define VSX_OFS_PRI4 12'h09c
`define VSX_OFS_PRI5 12'h09e
`define VSX_OFS_PRI6 12'h0a0
`define VSX_OFS_PRI7 12'h0a2
`define VSX_OFS_PRI8 12'h0a4
`define VSX_OFS_PRI9 12'h0a6
`define VSX_OFS_PRI10 12'h0a8
`define VSX_OFS_EN2 12'h600
`define VSX_OFS_CPU 12'h0b0
`define VSX_OFS_STAT 12'h0b4
// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define VSX_RST_PRI 16'h4444
`define VSX_RST_PRI9 16'h0444
`define VSX_RST_PRI10 16'h0440
`define VSX_RST_ZERO 16'h0000
`define VSX_BIT_ALT 15
`define VSX_TRAP_MASK 16'h871e
`define VSX_PRI_W 3
`define VSX_NUM_PRI 11
`define VSX_NUM_EXT 5
`define VSX_VEC_ENTRIES 8'd64
`endif

// ==== src/vsx_pkg.sv ====
package vsx_pkg;
   typedef logic [15:0] vsx_word_t;
   typedef logic [2:0] vsx_prio_t;
   typedef enum logic [2:0] {
      VSX_IDLE = 3'b001,
      VSX_DATA = 3'b010,
      VSX_DONE = 3'b100
   } vsx_bus_e;
endpackage

// ==== src/vsx_vector_select_shadow_extint_wake.sv ====
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "vsx_map.svh"
module vsx_vector_select_shadow_extint_wake #(
   parameter int NUM_EXT = `VSX_NUM_EXT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NUM_EXT-1:0] ext_irq_inputs,
   input wire logic [47:0] periph_events,
   input wire logic low_power_active,
   input wire logic vector_fetch,
   input wire logic [7:0] vector_index,
   output logic [8:0] vector_addr,
   output logic irq_request,
   output logic [5:0] irq_id,
   output logic [2:0] irq_level,
   output logic wake_request,
   input wire logic shadow_push,
   input wire logic shadow_pop,
   input wire logic [4:0] live_status,
   input wire logic [63:0] live_work,
   output logic [4:0] shadow_status,
   output logic [63:0] shadow_work
);
   import vsx_pkg::*;
   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   logic a_valid_reg;
   logic a_write_reg;
   logic [11:0] a_addr_reg;
   wire logic take = hsel && hready && htrans[1];
   wire logic rd_take = take && !hwrite;
   wire logic [11:0] ra = haddr[13:2];
   wire logic wr = a_valid_reg && a_write_reg;
   wire logic [11:0] wa = a_addr_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         a_valid_reg <= 1'b0;
         a_write_reg <= 1'b0;
         a_addr_reg <= 12'h000;
      end else if (hready) begin
         a_valid_reg <= take;
         a_write_reg <= hwrite;
         a_addr_reg <= ra;
      end
   end
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   vsx_word_t vec_ctrl_reg;
   vsx_word_t trap_reg;
   vsx_word_t flag_reg [3];
   vsx_word_t en_reg [3];
   vsx_word_t pri_reg [`VSX_NUM_PRI];
   vsx_prio_t cpu_priority_level_reg;
   logic [11:0] pri_ofs [`VSX_NUM_PRI];
   assign pri_ofs = '{`VSX_OFS_PRI0, `VSX_OFS_PRI1, `VSX_OFS_PRI2, `VSX_OFS_PRI3,
      `VSX_OFS_PRI4, `VSX_OFS_PRI5, `VSX_OFS_PRI6, `VSX_OFS_PRI7, `VSX_OFS_PRI8,
      `VSX_OFS_PRI9, `VSX_OFS_PRI10};
   wire logic [11:0] flag_ofs [3] = '{`VSX_OFS_FLAG0, `VSX_OFS_FLAG1, `VSX_OFS_FLAG2};
   wire logic [11:0] en_ofs [3] = '{`VSX_OFS_EN0, `VSX_OFS_EN1, `VSX_OFS_EN2};
   // ----------------------------------------
   // External edge detect
   // ----------------------------------------
   logic [NUM_EXT-1:0] sync1_reg;
   logic [NUM_EXT-1:0] sync2_reg;
   logic [NUM_EXT-1:0] prev_reg;
   wire logic [NUM_EXT-1:0] pol = vec_ctrl_reg[NUM_EXT-1:0];
   wire logic [NUM_EXT-1:0] ext_edge = (sync2_reg ^ prev_reg) & (sync2_reg ^ pol);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end else begin
         sync1_reg <= ext_irq_inputs;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end
   // Map external edges onto their flag bit positions
   logic [47:0] ext_flags;
   always_comb begin
      ext_flags = '0;
      ext_flags[0] = ext_edge[0];
      ext_flags[16] = ext_edge[1];
      ext_flags[23] = ext_edge[2];
      ext_flags[36] = ext_edge[3];
      ext_flags[37] = ext_edge[4];
   end
   wire logic [47:0] set_ev = ext_flags | periph_events;
   // ----------------------------------------
   // Flag, enable, priority storage
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_word
         wire logic fw = wr && (wa == flag_ofs[g]);
         wire logic ew = wr && (wa == en_ofs[g]);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               flag_reg[g] <= `VSX_RST_ZERO;
               en_reg[g] <= `VSX_RST_ZERO;
            end else begin
               flag_reg[g] <= (fw ? hwdata[15:0] : flag_reg[g]) | set_ev[g*16 +: 16];
               if (ew) begin
                  en_reg[g] <= hwdata[15:0];
               end
            end
         end
      end
      for (g = 0; g < `VSX_NUM_PRI; g++) begin : g_pri
         wire logic pw = wr && (wa == pri_ofs[g]);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pri_reg[g] <= (g == 9) ? `VSX_RST_PRI9 : (g == 10) ? `VSX_RST_PRI10 : `VSX_RST_PRI;
            end else if (pw) begin
               pri_reg[g] <= hwdata[15:0] & 16'h7777;
            end
         end
      end
   endgenerate
   // Write decode for the single control words
   wire logic wr_vec = wr && (wa == `VSX_OFS_VEC);
   wire logic wr_trap = wr && (wa == `VSX_OFS_TRAP);
   wire logic wr_cpu = wr && (wa == `VSX_OFS_CPU);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vec_ctrl_reg <= `VSX_RST_ZERO;
         trap_reg <= `VSX_RST_ZERO;
         cpu_priority_level_reg <= 3'h0;
      end else begin
         if (wr_vec) begin
            vec_ctrl_reg <= hwdata[15:0] & 16'h801f;
         end
         if (wr_trap) begin
            trap_reg <= hwdata[15:0] & `VSX_TRAP_MASK;
         end
         if (wr_cpu) begin
            cpu_priority_level_reg <= hwdata[2:0];
         end
      end
   end
   // ----------------------------------------
   // Priority evaluation
   // ----------------------------------------
   wire logic [47:0] pend = {flag_reg[2], flag_reg[1], flag_reg[0]} & {en_reg[2], en_reg[1], en_reg[0]};
   logic [5:0] src_pri_idx [48];
   vsx_prio_t src_prio [48];
   // Source n (n < 44) uses field n%4 of priority word n/4; sources 44-47 have priority 0
   generate
      for (g = 0; g < 48; g++) begin : g_src
         assign src_pri_idx[g] = 6'(g);
         if (g < 44) begin : g_has
            assign src_prio[g] = pri_reg[g / 4][(g % 4) * 4 +: 3];
         end else begin : g_none
            assign src_prio[g] = 3'h0;
         end
      end
   endgenerate
   logic best_valid;
   logic [5:0] best_id;
   vsx_prio_t best_pri;
   always_comb begin
      best_valid = 1'b0;
      best_id = 6'h00;
      best_pri = 3'h0;
      for (int n = 0; n < 48; n++) begin
         if (pend[n] && src_prio[n] > cpu_priority_level_reg && (!best_valid || src_prio[n] > best_pri)) begin
            best_valid = 1'b1;
            best_id = src_pri_idx[n];
            best_pri = src_prio[n];
         end
      end
   end
   // ----------------------------------------
   // Request, wake, vector fetch
   // ----------------------------------------
   logic alt_latched_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_request <= 1'b0;
         irq_id <= 6'h00;
         irq_level <= 3'h0;
         wake_request <= 1'b0;
         vector_addr <= 9'h000;
         alt_latched_reg <= 1'b0;
      end else begin
         irq_request <= best_valid;
         irq_id <= best_id;
         irq_level <= best_pri;
         wake_request <= best_valid && low_power_active;
         if (vector_fetch) begin
            alt_latched_reg <= vec_ctrl_reg[`VSX_BIT_ALT];
            vector_addr <= vec_ctrl_reg[`VSX_BIT_ALT] ? {1'b1, vector_index} : {1'b0, vector_index};
         end
      end
   end
   // ----------------------------------------
   // Shadow context
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shadow_status <= 5'h00;
         shadow_work <= 64'h0000_0000_0000_0000;
      end else if (shadow_push) begin
         shadow_status <= live_status;
         shadow_work <= live_work;
      end
   end
   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   // Decode on the address phase index
   wire logic hit_vec = (ra == `VSX_OFS_VEC);
   wire logic hit_trap = (ra == `VSX_OFS_TRAP);
   wire logic hit_cpu = (ra == `VSX_OFS_CPU);
   wire logic hit_stat = (ra == `VSX_OFS_STAT);
   wire vsx_word_t cpu_word = {13'h0000, cpu_priority_level_reg};
   wire vsx_word_t stat_word = {shadow_pop, alt_latched_reg, best_valid, best_pri, 4'h0, best_id};
   vsx_word_t rd;
   always_comb begin
      rd = 16'h0000;
      for (int i = 0; i < 3; i++) begin
         if (ra == flag_ofs[i]) rd = flag_reg[i];
         if (ra == en_ofs[i]) rd = en_reg[i];
      end
      for (int i = 0; i < `VSX_NUM_PRI; i++) begin
         if (ra == pri_ofs[i]) rd = pri_reg[i];
      end
      if (hit_vec) rd = vec_ctrl_reg;
      if (hit_trap) rd = trap_reg;
      if (hit_cpu) rd = cpu_word;
      if (hit_stat) rd = stat_word;
   end
   // ----------------------------------------
   // Bus response flops
   // ----------------------------------------
   // Read data captured at the address phase, stands through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (rd_take) begin
            hrdata <= {16'h0000, rd};
         end
      end
   end
endmodule

// ==== sim/vsx_check_monitor.sv ====
`timescale 1ns/1ps
`include "vsx_map.svh"
module vsx_check_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic low_power_active,
   input wire logic vector_fetch,
   input wire logic [7:0] vector_index,
   input wire logic [8:0] vector_addr,
   input wire logic irq_request,
   input wire logic [2:0] irq_level,
   input wire logic wake_request,
   input wire logic shadow_push,
   input wire logic [4:0] live_status,
   input wire logic [63:0] live_work,
   input wire logic [4:0] shadow_status,
   input wire logic [63:0] shadow_work
);
   // ----
   // Table select seen on the bus
   // ----
   logic wph, alt_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wph <= 1'b0;
         alt_q <= 1'b0;
      end else begin
         if (hready)
            wph <= hsel && htrans[1] && hwrite && haddr == {18'h0, `VSX_OFS_VEC, 2'b00};
         if (wph)
            alt_q <= hwdata[`VSX_BIT_ALT];
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_vec_alt: assert property (vector_fetch |=> vector_addr[8] == $past(alt_q)) else $error("bad table");
   a_vec_index: assert property (vector_fetch |=> vector_addr[7:0] == $past(vector_index)) else $error("bad entry");
   a_vec_hold: assert property (!vector_fetch |=> $stable(vector_addr)) else $error("vector moved");
   a_shadow_copy: assert property (shadow_push |=> shadow_status == $past(live_status)
      && shadow_work == $past(live_work)) else $error("bad shadow copy");
   a_shadow_hold: assert property (!shadow_push |=> $stable({shadow_status, shadow_work})) else $error("shadow moved");
   a_wake_rise: assert property ((irq_request && low_power_active) [*2] |-> wake_request) else $error("no wake");
   a_wake_low: assert property (!low_power_active |=> !wake_request) else $error("stray wake");
   a_irq_level: assert property (irq_request |-> irq_level != 3'h0) else $error("level zero request");
   cover property (shadow_push);
   cover property (wake_request);
   cover property (vector_fetch && alt_q);
endmodule
bind vsx_vector_select_shadow_extint_wake vsx_check_monitor mon (.*);

// ==== sim/vsx_core_model.sv ====
`timescale 1ns/1ps
module vsx_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic irq_request,
   input wire logic [5:0] irq_id,
   output logic vector_fetch,
   output logic [7:0] vector_index,
   output logic shadow_push,
   output logic shadow_pop,
   output logic [4:0] live_status,
   output logic [63:0] live_work
);
   // ----
   // Core entering and leaving service
   // ----
   logic irq_q, held;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {irq_q, held, vector_fetch, vector_index, shadow_push, shadow_pop, live_status} <= '0;
         live_work <= 64'h0000_0000_0000_0000;
      end else begin
         irq_q <= irq_request;
         vector_fetch <= irq_request && !irq_q;
         vector_index <= {2'b00, irq_id};
         shadow_push <= vector_fetch && !held;
         held <= (held || vector_fetch) && irq_request;
         shadow_pop <= held && !irq_request;
         live_status <= live_status + 5'h03;
         live_work <= {live_work[62:0], ~live_work[63]};
      end
   end
endmodule

// ==== sim/vector_select_shadow_extint_wake_tb.sv ====
`timescale 1ns/1ps
`include "vsx_map.svh"
module vector_select_shadow_extint_wake_tb;
   import vsx_pkg::*;
   // ----
   // Stimulus and observation
   // ----
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, low_power_active = 0, alt = 0, rph = 0, vph = 0, sph = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2, irq_level;
   logic [4:0] ext_irq_inputs = '0, pol, live_status, shadow_status;
   logic [47:0] periph_events = '0;
   logic [63:0] live_work, shadow_work;
   logic [7:0] vector_index;
   logic [8:0] vector_addr, vexp;
   logic [5:0] irq_id;
   logic [68:0] sexp;
   logic [15:0] d, rq[$];
   logic [11:0] ofs [11] = '{`VSX_OFS_PRI0, `VSX_OFS_PRI1, `VSX_OFS_PRI9, `VSX_OFS_PRI10, `VSX_OFS_VEC,
      `VSX_OFS_FLAG0, `VSX_OFS_FLAG2, `VSX_OFS_EN0, `VSX_OFS_EN2, `VSX_OFS_TRAP, 12'h0c0};
   logic hreadyout, hresp, vector_fetch, irq_request, wake_request, shadow_push, shadow_pop;
   wire hready;
   int fails = 0, checked = 0, cyc = 0;
   assign hready = hreadyout;
   vsx_vector_select_shadow_extint_wake dut (.*);
   vsx_core_model core (.*);
   always #2 hclk = ~hclk;
   task chk(input string n, input logic [68:0] e, input logic [68:0] s);
      checked++;
      if (s !== e) begin
         fails++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [15:0] v);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {18'h0, a, 2'b00};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {16'h0000, v};
      do @(posedge hclk); while (hready !== 1'b1);
   endtask
   task rd(input logic [11:0] a, input logic [15:0] e);
      rq.push_back(e);
      bus(1'b0, a, 16'h0000);
   endtask
   task flags(input logic [47:0] e);
      for (int i = 0; i < 3; i++)
         rd(`VSX_OFS_FLAG0 + 12'(2 * i), e[16 * i +: 16]);
   endtask
   task wt(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task tally_and_finish;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge hclk) begin
      if (rph && hready) begin
         chk("hrdata", {53'h0, rq.pop_front()}, {53'h0, hrdata[15:0]});
         chk("hresp", 69'h0, {68'h0, hresp});
      end
      if (hready)
         rph <= hsel && htrans[1] && !hwrite;
      if (vph)
         chk("vector_addr", {60'h0, vexp}, {60'h0, vector_addr});
      if (sph)
         chk("shadow", sexp, {shadow_status, shadow_work});
      vph <= vector_fetch;
      vexp <= {alt, vector_index};
      sph <= shadow_push;
      sexp <= {live_status, live_work};
   end
   always @(posedge hclk) begin
      if (++cyc == 5000) begin
         fails++;
         tally_and_finish;
      end
   end
   initial begin
      void'($urandom(58));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 11; i++)
         rd(ofs[i], i < 2 ? `VSX_RST_PRI : i == 2 ? `VSX_RST_PRI9 : i == 3 ? `VSX_RST_PRI10 : `VSX_RST_ZERO);
      $display("test reset done");
      d = 16'($urandom) & 16'h7777;
      bus(1'b1, `VSX_OFS_PRI3, d);
      bus(1'b1, 12'h0c0, 16'hffff);
      rd(`VSX_OFS_PRI3, d);
      rd(12'h0c0, 16'h0000);
      $display("test access done");
      pol = 5'($urandom);
      bus(1'b1, `VSX_OFS_VEC, {11'h000, pol});
      ext_irq_inputs <= pol;
      wt(8);
      flags(48'h0);
      ext_irq_inputs <= ~pol;
      wt(8);
      flags(48'h0030_0081_0001);
      chk("irq", 69'h0, {68'h0, irq_request});
      bus(1'b1, `VSX_OFS_EN0, 16'h0001);
      wt(4);
      chk("irq", 69'h204, {59'h0, irq_request, irq_id, irq_level});
      bus(1'b1, `VSX_OFS_CPU, 16'h0004);
      wt(4);
      chk("irq", 69'h0, {68'h0, irq_request});
      bus(1'b1, `VSX_OFS_VEC, {11'h400, pol});
      alt = 1'b1;
      low_power_active <= 1'b1;
      bus(1'b1, `VSX_OFS_CPU, 16'h0003);
      wt(4);
      chk("wake", 69'h3, {67'h0, irq_request, wake_request});
      rd(`VSX_OFS_VEC, {11'h400, pol});
      rd(`VSX_OFS_STAT, 16'h7000);
      low_power_active <= 1'b0;
      for (int i = 0; i < 3; i++)
         bus(1'b1, `VSX_OFS_FLAG0 + 12'(2 * i), 16'h0000);
      wt(8);
      flags(48'h0);
      chk("irq", 69'h0, {68'h0, irq_request});
      $display("test interrupt done");
      wt(2);
      tally_and_finish;
   end
endmodule
